// >>> hw/flr_readout.sv
// fuse, lock and signature readout with self-programming control
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module flr_readout
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic load_strobe,
    input wire logic store_strobe,
    input wire logic [15:0] load_addr,
    input wire logic [7:0] flash_byte,
    output logic [7:0] load_data,
    input wire logic [7:0] fuse_low_byte,
    input wire logic [7:0] fuse_high_byte,
    input wire logic [3:0] fuse_extended_byte,
    input wire logic [5:0] lock_bits,
    input wire logic [7:0] store_r0,
    input wire logic eeprom_write_active,
    output logic lock_write,
    output logic [5:0] lock_write_data,
    output logic page_buffer_flush,
    output logic flash_busy,
    output logic fetch_boot_only,
    output logic [13:0] boot_start
);
    import flr_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] self_prog_ctrl_reg;
    logic [7:0] sig_row [0:3];
    logic [2:0] win_cnt;
    logic [15:0] prog_cnt;
    logic prog_to_rww;
    logic prog_pend;
    logic [7:0] next_ctrl;
    flr_state_t state;
    flr_state_t next_state;

    wire self_prog_enable = self_prog_ctrl_reg[FLR_B_EN];
    wire lock_select_bit = self_prog_ctrl_reg[FLR_B_LCK];
    wire signature_select_bit = self_prog_ctrl_reg[FLR_B_SIG];
    wire page_write_cmd = self_prog_ctrl_reg[FLR_B_WRT];
    wire page_erase_cmd = self_prog_ctrl_reg[FLR_B_ERS];
    wire section_read_reenable = self_prog_ctrl_reg[FLR_B_RRE];
    wire section_busy_flag = self_prog_ctrl_reg[FLR_B_BSY];

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire acc = psel & penable;
    wire hit_ctrl = paddr == FLR_CTRL_OFF;
    wire hit_stat = paddr == FLR_STAT_OFF;
    wire hit_sig = paddr[11:4] == FLR_SIG_OFF[11:4];
    wire hit_zptr = paddr == FLR_ZPTR_OFF;
    wire mapped = hit_ctrl | hit_stat | hit_sig | hit_zptr;
    // eeprom write blocks arming; busy programming refuses new commands
    wire ctrl_wr = acc & pwrite & hit_ctrl & ~eeprom_write_active
                   & (state != FLR_PROG);
    wire sig_wr = acc & pwrite & (paddr[11:4] == 8'h01);
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped & (paddr[11:4] != 8'h01);

    // ----------------------------------------------------------------
    // armed load decode
    // ----------------------------------------------------------------
    wire armed = (state == FLR_ARMED);
    // a load only substitutes inside the three-cycle window; stores get four
    wire load_win = win_cnt < FLR_LOAD_WIN;
    wire lock_armed = armed & lock_select_bit & self_prog_enable
                      & load_win;
    wire sig_armed = armed & signature_select_bit & self_prog_enable
                     & load_win;
    wire [7:0] lock_byte = {2'b11, lock_bits};
    wire [7:0] ext_byte = {4'hf, fuse_extended_byte};
    // raw fuse levels are passed through: programmed = 0 by convention
    wire [7:0] fuse_sel = (load_addr == FLR_Z_LOCK) ? lock_byte
                        : (load_addr == FLR_Z_FHIGH) ? fuse_high_byte
                        : (load_addr == FLR_Z_FEXT) ? ext_byte
                        : fuse_low_byte;
    wire [7:0] sig_sel = sig_row[load_addr[1:0]];
    assign load_data = lock_armed ? fuse_sel
                     : sig_armed ? sig_sel : flash_byte;
    wire is_cmd = page_erase_cmd | page_write_cmd
                  | (lock_select_bit & ~signature_select_bit);
    wire store_go = armed & store_strobe & self_prog_enable
                    & win_cnt < FLR_STORE_WIN;
    wire win_load_over = win_cnt >= FLR_LOAD_WIN;
    wire win_store_over = win_cnt >= FLR_STORE_WIN;
    wire prog_done = (state == FLR_PROG)
                     & (prog_cnt == 16'(FLR_PROG_CYC - 1));
    wire rww_target = load_addr[15:1] < {1'b0, boot_start};

    // ----------------------------------------------------------------
    // boot section size
    // ----------------------------------------------------------------
    always_comb
    begin
        case (fuse_high_byte[2:1])
            2'b11: boot_start = FLR_BOOT_256;
            2'b10: boot_start = FLR_BOOT_512;
            2'b01: boot_start = FLR_BOOT_1K;
            default: boot_start = FLR_BOOT_2K;
        endcase
    end

    // ----------------------------------------------------------------
    // control next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_ctrl = self_prog_ctrl_reg;
        next_state = state;
        case (state)
            FLR_IDLE:
            begin
                if (ctrl_wr)
                begin
                    // busy is hardware owned, software writes ignored
                    next_ctrl = {pwdata[7], section_busy_flag,
                                 pwdata[5:0]};
                    if (pwdata[FLR_B_EN])
                        next_state = FLR_ARMED;
                end
            end
            FLR_ARMED:
            begin
                if ((lock_armed | sig_armed) & load_strobe)
                begin
                    next_ctrl[5:0] = 6'h00;
                    next_state = FLR_IDLE;
                end
                else if (store_go & section_read_reenable)
                begin
                    next_ctrl[FLR_B_BSY] = 1'b0;
                    next_ctrl[5:0] = 6'h00;
                    next_state = FLR_IDLE;
                end
                else if (store_go & ~signature_select_bit & is_cmd)
                begin
                    if ((page_erase_cmd | page_write_cmd) & rww_target)
                        next_ctrl[FLR_B_BSY] = 1'b1;
                    next_state = FLR_PROG;
                end
                else if (store_go & ~signature_select_bit)
                begin
                    // page load also releases the busy section
                    next_ctrl[FLR_B_BSY] = 1'b0;
                    next_ctrl[5:0] = 6'h00;
                    next_state = FLR_IDLE;
                end
                else if ((signature_select_bit & win_load_over)
                         | win_store_over)
                begin
                    next_ctrl[5:0] = 6'h00;
                    next_state = FLR_IDLE;
                end
            end
            FLR_PROG:
            begin
                if (prog_done)
                begin
                    next_ctrl[5:0] = 6'h00;
                    next_state = FLR_IDLE;
                end
            end
            default:
                next_state = FLR_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            self_prog_ctrl_reg <= FLR_CTRL_RST;
            state <= FLR_IDLE;
        end
        else
        begin
            self_prog_ctrl_reg <= next_ctrl;
            state <= next_state;
        end
    end

    // the programming timer sits outside reset and clears once state leaves FLR_PROG
    always_ff @(posedge clock)
    begin
        if (state == FLR_PROG & ~prog_done)
            prog_cnt <= prog_cnt + 16'h0001;
        else
            prog_cnt <= 16'h0000;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            prog_pend <= 1'b0;
        else
            prog_pend <= (next_state == FLR_PROG);
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            win_cnt <= 3'h0;
        else if (state == FLR_ARMED)
            win_cnt <= win_cnt + 3'h1;
        else
            win_cnt <= 3'h0;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            prog_to_rww <= 1'b0;
        else if (store_go & (page_erase_cmd | page_write_cmd))
            prog_to_rww <= rww_target;
    end

    always_ff @(posedge clock)
    begin
        if (sig_wr)
            sig_row[paddr[3:2]] <= pwdata[7:0];
    end

    // lock write pulses once when the timed operation ends
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lock_write <= 1'b0;
            lock_write_data <= 6'h3f;
        end
        else
        begin
            lock_write <= prog_done & lock_select_bit;
            if (store_go & lock_select_bit)
                lock_write_data <= store_r0[5:0] & lock_bits;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign page_buffer_flush = store_go & section_read_reenable;
    assign flash_busy = prog_pend;
    assign fetch_boot_only = prog_pend
                             & (page_erase_cmd | page_write_cmd);
    assign prdata = ~acc | pwrite ? 32'h0000_0000
                  : hit_ctrl ? {24'h0, self_prog_ctrl_reg}
                  : hit_stat ? {16'h0, 2'b00, boot_start}
                  : hit_zptr ? {16'h0, load_addr}
                  : 32'h0000_0000;
endmodule : flr_readout
`default_nettype wire

// >>> hw/flr_pkg.sv
// package: offsets, fields, timing constants for the fuse/lock readout block
package flr_pkg;
    // ----------------------------------------------------------------
    // register map (apb byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] FLR_CTRL_OFF = 12'h000;
    localparam logic [11:0] FLR_ZPTR_OFF = 12'h004;
    localparam logic [11:0] FLR_STAT_OFF = 12'h008;
    localparam logic [11:0] FLR_SIG_OFF = 12'h00c;
    localparam logic [7:0] FLR_CTRL_RST = 8'h00;
    // ----------------------------------------------------------------
    // control bit positions
    // ----------------------------------------------------------------
    localparam int FLR_B_EN = 0;
    localparam int FLR_B_ERS = 1;
    localparam int FLR_B_WRT = 2;
    localparam int FLR_B_LCK = 3;
    localparam int FLR_B_RRE = 4;
    localparam int FLR_B_SIG = 5;
    localparam int FLR_B_BSY = 6;
    localparam int FLR_B_IE = 7;
    // ----------------------------------------------------------------
    // pointer values for lock/fuse reads
    // ----------------------------------------------------------------
    localparam logic [15:0] FLR_Z_FLOW = 16'h0000;
    localparam logic [15:0] FLR_Z_LOCK = 16'h0001;
    localparam logic [15:0] FLR_Z_FEXT = 16'h0002;
    localparam logic [15:0] FLR_Z_FHIGH = 16'h0003;
    // ----------------------------------------------------------------
    // arm windows and programming time
    // ----------------------------------------------------------------
    localparam logic [2:0] FLR_LOAD_WIN = 3'h3;
    localparam logic [2:0] FLR_STORE_WIN = 3'h4;
    localparam int FLR_CLK_HZ = 10000000;
    localparam real FLR_PROG_MS = 3.2;
    localparam int FLR_PROG_CYC = int'(FLR_PROG_MS * FLR_CLK_HZ / 1000.0 + 0.999);
    // ----------------------------------------------------------------
    // boot section starts, word addresses
    // ----------------------------------------------------------------
    localparam logic [13:0] FLR_BOOT_256 = 14'h3f00;
    localparam logic [13:0] FLR_BOOT_512 = 14'h3e00;
    localparam logic [13:0] FLR_BOOT_1K = 14'h3c00;
    localparam logic [13:0] FLR_BOOT_2K = 14'h3800;
    localparam logic [13:0] FLR_BOOT_END = 14'h3fff;
    typedef enum logic [1:0] {FLR_IDLE, FLR_ARMED, FLR_PROG} flr_state_t;
endpackage : flr_pkg

// >>> verification/flr_readout_checker.sv
// port assertions for the fuse, lock and signature readout block
`timescale 1ns/100ps
`default_nettype none
module flr_readout_checker
    import flr_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic load_strobe,
    input wire logic store_strobe,
    input wire logic [15:0] load_addr,
    input wire logic [7:0] flash_byte,
    input wire logic [7:0] load_data,
    input wire logic [7:0] fuse_high_byte,
    input wire logic [5:0] lock_bits,
    input wire logic eeprom_write_active,
    input wire logic page_buffer_flush,
    input wire logic flash_busy,
    input wire logic fetch_boot_only,
    input wire logic [13:0] boot_start
);
    localparam int PROG_MIN = 32000;
    localparam int PROG_MAX = 34000;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic [3:0] since_arm;
    logic [7:0] arm_val;
    logic fresh;
    logic [15:0] busy_len;
    // arming is refused while programming or an eeprom write runs
    wire arm_take = psel && penable && pwrite && paddr == FLR_CTRL_OFF
        && pwdata[0] && !eeprom_write_active && !flash_busy;
    wire in_win = fresh && since_arm < 4'h3;
    wire st_win = store_strobe && fresh && since_arm < 4'h4;
    wire [13:0] boot_exp = fuse_high_byte[2] ?
        (fuse_high_byte[1] ? FLR_BOOT_256 : FLR_BOOT_512) :
        (fuse_high_byte[1] ? FLR_BOOT_1K : FLR_BOOT_2K);
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            since_arm <= 4'hf;
            fresh <= 1'b0;
            arm_val <= 8'h00;
        end
        else if (arm_take)
        begin
            since_arm <= 4'h0;
            fresh <= 1'b1;
            arm_val <= pwdata[7:0];
        end
        else
        begin
            since_arm <= (since_arm == 4'hf) ? since_arm : since_arm + 4'h1;
            fresh <= fresh && !load_strobe;
        end
    end
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            busy_len <= 16'h0000;
        else
            busy_len <= flash_busy ? busy_len + 16'h0001 : 16'h0000;
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    ready_zero_wait_a: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    unmapped_err_a: assert property (psel && penable && paddr > 12'h01c
        |-> pslverr) else $error("no error on unmapped address");
    boot_map_a: assert property (boot_start == boot_exp)
        else $error("boot start does not follow size fuses");
    lock_read_a: assert property (
        load_strobe && in_win && arm_val[5:0] == 6'h09
        && load_addr == FLR_Z_LOCK |-> load_data == {2'b11, lock_bits})
        else $error("lock byte read wrong");
    plain_load_a: assert property (
        load_strobe && (!fresh || since_arm > 4'h2)
        |-> load_data == flash_byte) else $error("plain load wrong");
    prog_time_a: assert property ($fell(flash_busy) |->
        busy_len >= PROG_MIN && busy_len <= PROG_MAX)
        else $error("program time out of range");
    flush_store_a: assert property (
        st_win && arm_val[5:0] == 6'h11 |-> page_buffer_flush)
        else $error("no page buffer flush");
    erase_fetch_a: assert property (
        st_win && arm_val[5:0] == 6'h03 |-> ##[1:3] fetch_boot_only)
        else $error("boot fetch limit missing");
endmodule : flr_readout_checker
bind flr_readout flr_readout_checker u_flr_readout_checker (.*);
`default_nettype wire

// >>> verification/flr_cpu_model.sv
// cpu core model issuing program-memory load and store pulses
`timescale 1ns/100ps
`default_nettype none
module flr_cpu_model
(
    input wire logic clock,
    output logic load_strobe,
    output logic store_strobe,
    output logic [15:0] load_addr
);
    initial
    begin
        load_strobe = 1'b0;
        store_strobe = 1'b0;
        load_addr = 16'hffff;
    end
    // pointer is scrambled after use so a stale value never matches
    task automatic issue(input logic st, input logic [15:0] a, input int d);
        repeat (d) @(posedge clock);
        load_addr <= a;
        load_strobe <= !st;
        store_strobe <= st;
        @(posedge clock);
        load_strobe <= 1'b0;
        store_strobe <= 1'b0;
        load_addr <= ~a;
    endtask : issue
endmodule : flr_cpu_model
`default_nettype wire

// >>> verification/tb_fuse_lock_signature_readout.sv
// self-checking bench for the fuse, lock and signature readout
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    fails++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_fuse_lock_signature_readout;
    import flr_pkg::*;
    logic clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, load_strobe, store_strobe;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] load_addr;
    logic [7:0] flash_byte = 8'h00, load_data, fuse_low_byte = 8'hff;
    logic [7:0] fuse_high_byte = 8'hff, store_r0 = 8'hff, sv, ev;
    logic [3:0] fuse_extended_byte = 4'hf;
    logic [5:0] lock_bits = 6'h3f, lock_write_data;
    logic eeprom_write_active = 1'b0, lock_write, page_buffer_flush, err;
    logic flash_busy, fetch_boot_only;
    logic [13:0] boot_start;
    logic [13:0] boots [4] = '{FLR_BOOT_2K, FLR_BOOT_1K, FLR_BOOT_512,
        FLR_BOOT_256};
    logic [7:0] exp_tab [4];
    logic [7:0] exp_q [$];
    int seed = 37, i, fails = 0, checks_done = 0, cycles = 0;
    flr_readout u_flr_readout (.*);
    flr_cpu_model u_flr_cpu_model (.*);
    always #50 clock = ~clock;
    task stop_test;
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            fails++;
            stop_test();
        end
    end
    always @(negedge clock)
    begin
        if (load_strobe === 1'b1)
        begin
            ev = exp_q.pop_front();
            `CHK("load_data", ev, load_data)
        end
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        fuse_low_byte <= 8'($random(seed));
        fuse_extended_byte <= 4'($random(seed));
        lock_bits <= 6'($random(seed));
        flash_byte <= 8'($random(seed));
        sv = 8'($random(seed));
        apb(1'b0, FLR_CTRL_OFF, 8'h00);
        `CHK("ctrl", 8'h00, rd[7:0])
        for (i = 0; i < 4; i++)
        begin
            fuse_high_byte[2:1] <= 2'(i);
            @(posedge clock);
            `CHK("boot_start", boots[i], boot_start)
        end
        exp_tab = '{fuse_low_byte, {2'b11, lock_bits},
            {4'hf, fuse_extended_byte}, fuse_high_byte};
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, FLR_CTRL_OFF, 8'h09);
            exp_q.push_back(exp_tab[i]);
            u_flr_cpu_model.issue(1'b0, 16'(i), i % 3);
        end
        // late loads, and an arm refused under an eeprom write
        for (i = 0; i < 3; i++)
        begin
            eeprom_write_active <= (i == 2);
            apb(1'b1, FLR_CTRL_OFF, i == 1 ? 8'h21 : 8'h09);
            exp_q.push_back(flash_byte);
            u_flr_cpu_model.issue(1'b0, 16'h0001, i == 2 ? 0 : 3);
        end
        eeprom_write_active <= 1'b0;
        apb(1'b0, FLR_CTRL_OFF, 8'h00);
        `CHK("ctrl", 6'h00, rd[5:0])
        for (i = 0; i < 4; i++)
            apb(1'b1, 12'h010 + 12'(4 * i), sv);
        apb(1'b1, FLR_CTRL_OFF, 8'h21);
        exp_q.push_back(sv);
        u_flr_cpu_model.issue(1'b0, 16'h0002, 1);
        exp_q.push_back(flash_byte);
        u_flr_cpu_model.issue(1'b0, 16'h0002, 1);
        apb(1'b0, 12'h100, 8'h00);
        `CHK("pslverr", 1'b1, err)
        store_r0 <= {2'b11, 6'($random(seed))};
        apb(1'b1, FLR_CTRL_OFF, 8'h09);
        u_flr_cpu_model.issue(1'b1, 16'h0001, 3);
        repeat (2) @(posedge clock);
        `CHK("flash_busy", 1'b1, flash_busy)
        while (flash_busy !== 1'b0) @(posedge clock);
        @(posedge clock);
        `CHK("lock_data", store_r0[5:0] & lock_bits, lock_write_data)
        apb(1'b1, FLR_CTRL_OFF, 8'h03);
        u_flr_cpu_model.issue(1'b1, 16'h0000, 0);
        repeat (2) @(posedge clock);
        `CHK("boot_fetch", 1'b1, fetch_boot_only)
        apb(1'b0, FLR_CTRL_OFF, 8'h00);
        `CHK("sect_busy", 1'b1, rd[6])
        while (flash_busy !== 1'b0) @(posedge clock);
        apb(1'b1, FLR_CTRL_OFF, 8'h11);
        u_flr_cpu_model.issue(1'b1, 16'h0000, 0);
        apb(1'b0, FLR_CTRL_OFF, 8'h00);
        `CHK("sect_busy", 1'b0, rd[6])
        stop_test();
    end
endmodule : tb_fuse_lock_signature_readout
`default_nettype wire
